// *** rtl/branch_bit_flag_exec.sv ***
// What this block does
// - Taken branch: pc plus offset plus one, two cycles
// - Carry and negative branches test C or N
// - Signed branches test N xor V
// - Half-carry branch pair tests H
// - T flag branch pair tests T
// - Overflow branch pair tests V
// - Interrupt-enable branch pair; branches keep flags
// - I/O bit set/clear, two cycles, flags kept
// - Left shifts/rotate, one cycle, Z C N V
// - Right shifts/rotate/arith, one cycle, Z C N V
// - Bit to T, T to bit, one cycle
// - Indexed flag set/clear, each own flag only
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module branch_bit_flag_exec
  import exec_pkg::*;
#(
  parameter int PC_W = exec_pkg::PC_W_DEF
)
(
  input  wire logic                              mclk,
  input  wire logic                              rstn,
  input  wire logic                              instr_valid,
  output logic                                   instr_ready,
  input  wire exec_pkg::op_type                  instr_op,
  input  wire logic [exec_pkg::OFFSET_W-1:0]     instr_offset,
  input  wire logic [exec_pkg::BIT_IDX_W-1:0]    instr_index,
  input  wire logic [exec_pkg::IO_ADDR_W-1:0]    instr_io_addr,
  input  wire logic [exec_pkg::DATA_W-1:0]       instr_rd_val,
  output logic                                   reg_we,
  output logic [exec_pkg::DATA_W-1:0]            reg_wdata,
  output logic                                   io_re,
  output logic                                   io_we,
  output logic [exec_pkg::IO_ADDR_W-1:0]         io_addr,
  output logic [exec_pkg::DATA_W-1:0]            io_wdata,
  input  wire logic [exec_pkg::DATA_W-1:0]       io_rd_data,
  output logic [PC_W-1:0]                        pc,
  output logic [exec_pkg::DATA_W-1:0]            status,
  input  wire logic [exec_pkg::AV_ADDR_W-1:0]    avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [exec_pkg::AV_DATA_W-1:0]    avs_writedata,
  output logic [exec_pkg::AV_DATA_W-1:0]         avs_readdata,
  output logic                                   avs_waitrequest
);
  import exec_pkg::*;

  typedef struct packed {
    phase_type               phase;
    logic [PC_W-1:0]         pc;
    logic [DATA_W-1:0]       status;
    logic                    ready;
    logic                    reg_we;
    logic [DATA_W-1:0]       reg_wdata;
    logic                    io_re;
    logic                    io_we;
    logic [IO_ADDR_W-1:0]    io_addr;
    logic [BIT_IDX_W-1:0]    io_bit;
    logic                    io_set;
    logic [DATA_W-1:0]       io_wdata;
    logic                    waitreq;
    logic [AV_DATA_W-1:0]    readdata;
  } state_type;

  localparam state_type STATE_RST = '{
    phase:     st_idle,
    pc:        '0,
    status:    STATUS_RST,
    ready:     1'b1,
    reg_we:    1'b0,
    reg_wdata: '0,
    io_re:     1'b0,
    io_we:     1'b0,
    io_addr:   '0,
    io_bit:    '0,
    io_set:    1'b0,
    io_wdata:  '0,
    waitreq:   1'b1,
    readdata:  '0
  };
  localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);

  state_type              q;
  state_type              d;
  logic                   accept;
  logic                   br_cond;
  logic                   bus_wr;
  logic [PC_W-1:0]        offset_ext;
  logic [PC_W-1:0]        pc_next_seq;
  logic [PC_W-1:0]        pc_branch;
  logic [DATA_W-1:0]      sh_dout;
  logic                   sh_c;
  logic                   sh_z;
  logic                   sh_n;
  logic                   sh_v;

  assign accept      = instr_valid && q.ready;
  assign bus_wr      = avs_write && !q.waitreq;
  assign offset_ext  = PC_W'($signed(instr_offset));
  assign pc_next_seq = q.pc + PC_ONE;
  assign pc_branch   = q.pc + offset_ext + PC_ONE;

  shift_unit u_shift (
    .op        (instr_op),
    .din       (instr_rd_val),
    .carry_in  (q.status[FLAG_C]),
    .dout      (sh_dout),
    .carry_out (sh_c),
    .zero_out  (sh_z),
    .neg_out   (sh_n),
    .ovf_out   (sh_v)
  );

  // Generic flag test covers the carry, minus, H, T, V and I pairs
  always_comb
  begin
    case (instr_op)
      op_branch_flag_set:   br_cond = q.status[instr_index];
      op_branch_flag_clear: br_cond = !q.status[instr_index];
      op_branch_signed_ge:  br_cond = !(q.status[FLAG_N] ^ q.status[FLAG_V]);
      op_branch_signed_lt:  br_cond = q.status[FLAG_N] ^ q.status[FLAG_V];
      default:              br_cond = 1'b0;
    endcase
  end

  always_comb
  begin
    d        = q;
    d.reg_we = 1'b0;
    d.io_re  = 1'b0;
    d.io_we  = 1'b0;
    case (q.phase)
      st_idle:
      begin
        if (accept)
        begin
          d.pc = pc_next_seq;
          case (instr_op)
            op_branch_flag_set, op_branch_flag_clear,
            op_branch_signed_ge, op_branch_signed_lt:
            begin
              // Status untouched on every branch path
              if (br_cond)
              begin
                d.pc    = pc_branch;
                d.ready = 1'b0;
                d.phase = st_branch;
              end
            end
            op_io_bit_set, op_io_bit_clear:
            begin
              d.io_re   = 1'b1;
              d.io_addr = instr_io_addr;
              d.io_bit  = instr_index;
              d.io_set  = (instr_op == op_io_bit_set);
              d.ready   = 1'b0;
              d.phase   = st_io_read;
            end
            op_shift_left_logical, op_rotate_left_carry,
            op_shift_right_logical, op_rotate_right_carry, op_shift_right_arith:
            begin
              d.reg_we         = 1'b1;
              d.reg_wdata      = sh_dout;
              d.status[FLAG_C] = sh_c;
              d.status[FLAG_Z] = sh_z;
              d.status[FLAG_N] = sh_n;
              d.status[FLAG_V] = sh_v;
            end
            op_flag_set_indexed:
              d.status[instr_index] = 1'b1;
            op_flag_clear_indexed:
              d.status[instr_index] = 1'b0;
            op_bit_to_tflag:
              d.status[FLAG_T] = instr_rd_val[instr_index];
            op_tflag_to_bit:
            begin
              d.reg_we                 = 1'b1;
              d.reg_wdata              = instr_rd_val;
              d.reg_wdata[instr_index] = q.status[FLAG_T];
            end
            default:
            begin
              d.pc = pc_next_seq;
            end
          endcase
        end
      end
      st_branch:
      begin
        d.ready = 1'b1;
        d.phase = st_idle;
      end
      st_io_read:
      begin
        // Other bits are written back as read, so write-one-to-clear flags nearby that read 1 get cleared
        d.io_we            = 1'b1;
        d.io_wdata         = io_rd_data;
        d.io_wdata[q.io_bit] = q.io_set;
        d.ready            = 1'b1;
        d.phase            = st_idle;
      end
      default:
      begin
        d.ready = 1'b1;
        d.phase = st_idle;
      end
    endcase

    // One wait state per access keeps the read mux off the bus path
    if (!q.waitreq)
    begin
      d.waitreq = 1'b1;
    end
    else if (avs_read || avs_write)
    begin
      d.waitreq = 1'b0;
      case (avs_address)
        ADDR_STATUS: d.readdata = AV_DATA_W'(q.status);
        ADDR_PC:     d.readdata = AV_DATA_W'(q.pc);
        default:     d.readdata = '0;
      endcase
    end
    // Software write overrides the instruction in the same cycle
    if (bus_wr)
    begin
      case (avs_address)
        ADDR_STATUS: d.status = avs_writedata[DATA_W-1:0];
        ADDR_PC:     d.pc = avs_writedata[PC_W-1:0];
        default:     d.status = d.status;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      q <= STATE_RST;
    else
      q <= d;
  end

  assign instr_ready     = q.ready;
  assign reg_we          = q.reg_we;
  assign reg_wdata       = q.reg_wdata;
  assign io_re           = q.io_re;
  assign io_we           = q.io_we;
  assign io_addr         = q.io_addr;
  assign io_wdata        = q.io_wdata;
  assign pc              = q.pc;
  assign status          = q.status;
  assign avs_readdata    = q.readdata;
  assign avs_waitrequest = q.waitreq;

  logic is_branch;
  logic is_shift;
  assign is_branch = (instr_op inside {op_branch_flag_set, op_branch_flag_clear,
                                       op_branch_signed_ge, op_branch_signed_lt});
  assign is_shift  = (instr_op inside {op_shift_left_logical, op_rotate_left_carry,
                      op_shift_right_logical, op_rotate_right_carry, op_shift_right_arith});

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_BRANCH_TAKEN: assert property (
    accept && is_branch && br_cond && !bus_wr |=>
      pc == $past(q.pc) + $past(offset_ext) + PC_ONE && !instr_ready ##1 instr_ready)
    else $error("taken branch pc or timing wrong");
  AST_BRANCH_NOT_TAKEN: assert property (
    accept && is_branch && !br_cond && !bus_wr |=> pc == $past(q.pc) + PC_ONE && instr_ready)
    else $error("untaken branch pc or timing wrong");
  AST_BRANCH_KEEPS_FLAGS: assert property (
    accept && is_branch && !bus_wr |=> $stable(status))
    else $error("branch altered status");
  AST_SIGNED_LT: assert property (
    accept && instr_op == op_branch_signed_lt && !bus_wr &&
      (status[FLAG_N] != status[FLAG_V]) |=> !instr_ready)
    else $error("signed less-than not taken");
  AST_IO_SEQUENCE: assert property (
    accept && (instr_op inside {op_io_bit_set, op_io_bit_clear}) |=>
      io_re && !instr_ready ##1 io_we && instr_ready)
    else $error("io bit sequence wrong");
  AST_IO_BIT_VALUE: assert property (
    io_re |=> io_wdata[$past(q.io_bit)] == $past(q.io_set))
    else $error("io bit not forced");
  AST_SHIFT_ONE_CYCLE: assert property (
    accept && is_shift && !bus_wr |=>
      reg_we && instr_ready && status[FLAG_Z] == (reg_wdata == '0))
    else $error("shift result or zero flag wrong");
  AST_TFLAG_STORE: assert property (
    accept && instr_op == op_bit_to_tflag && !bus_wr |=>
      status[FLAG_T] == $past(instr_rd_val[instr_index]))
    else $error("bit not stored in T");
  AST_FLAG_SET_ONLY_OWN: assert property (
    accept && instr_op == op_flag_set_indexed && !bus_wr |=>
      status == ($past(status) | (8'h01 << $past(instr_index))))
    else $error("indexed flag set wrong");

  COV_BRANCH_TAKEN: cover property (accept && is_branch && br_cond);
  COV_IO_SET: cover property (accept && instr_op == op_io_bit_set ##2 io_we);
  COV_ROTATE_RIGHT: cover property (accept && instr_op == op_rotate_right_carry);
  COV_BUS_READ: cover property (avs_read && !avs_waitrequest);

endmodule

// *** rtl/exec_pkg.sv ***
package exec_pkg;

  localparam int DATA_W     = 8;
  localparam int OFFSET_W   = 7;
  localparam int IO_ADDR_W  = 5;
  localparam int BIT_IDX_W  = 3;
  localparam int PC_W_DEF   = 12;
  localparam int AV_ADDR_W  = 4;
  localparam int AV_DATA_W  = 32;

  // Status register bit positions
  localparam logic [BIT_IDX_W-1:0] FLAG_C = 3'h0;
  localparam logic [BIT_IDX_W-1:0] FLAG_Z = 3'h1;
  localparam logic [BIT_IDX_W-1:0] FLAG_N = 3'h2;
  localparam logic [BIT_IDX_W-1:0] FLAG_V = 3'h3;
  localparam logic [BIT_IDX_W-1:0] FLAG_S = 3'h4;
  localparam logic [BIT_IDX_W-1:0] FLAG_H = 3'h5;
  localparam logic [BIT_IDX_W-1:0] FLAG_T = 3'h6;
  localparam logic [BIT_IDX_W-1:0] FLAG_I = 3'h7;

  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;

  // Bus byte addresses
  localparam logic [AV_ADDR_W-1:0] ADDR_STATUS = 4'h0;
  localparam logic [AV_ADDR_W-1:0] ADDR_PC     = 4'h4;

  typedef enum logic [3:0] {
    op_nop                 = 4'b0000,
    op_branch_flag_set     = 4'b0001,
    op_branch_flag_clear   = 4'b0010,
    op_branch_signed_ge    = 4'b0011,
    op_branch_signed_lt    = 4'b0100,
    op_io_bit_set          = 4'b0101,
    op_io_bit_clear        = 4'b0110,
    op_shift_left_logical  = 4'b0111,
    op_rotate_left_carry   = 4'b1000,
    op_shift_right_logical = 4'b1001,
    op_rotate_right_carry  = 4'b1010,
    op_shift_right_arith   = 4'b1011,
    op_flag_set_indexed    = 4'b1100,
    op_flag_clear_indexed  = 4'b1101,
    op_bit_to_tflag        = 4'b1110,
    op_tflag_to_bit        = 4'b1111
  } op_type;

  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_branch  = 2'b01,
    st_io_read = 2'b10
  } phase_type;

endpackage

// *** rtl/shift_unit.sv ***
`timescale 1ns/10ps
module shift_unit
  import exec_pkg::*;
(
  input  wire exec_pkg::op_type      op,
  input  wire logic [exec_pkg::DATA_W-1:0] din,
  input  wire logic                  carry_in,
  output logic [exec_pkg::DATA_W-1:0] dout,
  output logic                       carry_out,
  output logic                       zero_out,
  output logic                       neg_out,
  output logic                       ovf_out
);
  import exec_pkg::*;

  always_comb
  begin
    dout      = din;
    carry_out = carry_in;
    case (op)
      op_shift_left_logical:
      begin
        dout      = {din[DATA_W-2:0], 1'b0};
        carry_out = din[DATA_W-1];
      end
      op_rotate_left_carry:
      begin
        dout      = {din[DATA_W-2:0], carry_in};
        carry_out = din[DATA_W-1];
      end
      op_shift_right_logical:
      begin
        dout      = {1'b0, din[DATA_W-1:1]};
        carry_out = din[0];
      end
      op_rotate_right_carry:
      begin
        dout      = {carry_in, din[DATA_W-1:1]};
        carry_out = din[0];
      end
      op_shift_right_arith:
      begin
        dout      = {din[DATA_W-1], din[DATA_W-1:1]};
        carry_out = din[0];
      end
      default:
      begin
        dout      = din;
        carry_out = carry_in;
      end
    endcase
    zero_out = (dout == '0);
    neg_out  = dout[DATA_W-1];
    // Overflow follows sign versus carry out, as for any shift
    ovf_out  = neg_out ^ carry_out;
  end

endmodule

// *** tb/io_space.sv ***
`timescale 1ns/10ps
module io_space
(
  input  wire logic       mclk,
  input  wire logic       io_re,
  input  wire logic       io_we,
  input  wire logic [4:0] io_addr,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rd_data
);
  logic [7:0] mem [32];
  logic [7:0] last_q;

  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 8'(i * 29) ^ 8'h5a;
    last_q = 8'h00;
  end

  // Unselected space shows inverted stale data, so a late sample cannot match
  assign io_rd_data = io_re ? mem[io_addr] : ~last_q;

  always @(posedge mclk)
  begin
    if (io_re)
      last_q <= mem[io_addr];
    if (io_we)
      mem[io_addr] <= io_wdata;
  end
endmodule

// *** tb/test_branch_bit_flag_exec.sv ***
`timescale 1ns/10ps
module test_branch_bit_flag_exec;
  import exec_pkg::*;
  logic        mclk;
  logic        rstn;
  logic        instr_valid;
  logic        instr_ready;
  op_type      instr_op;
  logic [6:0]  instr_offset;
  logic [2:0]  instr_index;
  logic [4:0]  instr_io_addr;
  logic [7:0]  instr_rd_val;
  logic        reg_we;
  logic [7:0]  reg_wdata;
  logic        io_re;
  logic        io_we;
  logic [4:0]  io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rd_data;
  logic [11:0] pc;
  logic [7:0]  status;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          err_count;
  int          n_tests;
  logic [31:0] rs;
  logic [31:0] d;
  logic [7:0]  st;
  logic [11:0] pcx;
  logic [7:0]  iom [32];

  branch_bit_flag_exec #(.PC_W(12)) dut (.mclk, .rstn, .instr_valid, .instr_ready, .instr_op,
    .instr_offset, .instr_index, .instr_io_addr, .instr_rd_val, .reg_we, .reg_wdata, .io_re,
    .io_we, .io_addr, .io_wdata, .io_rd_data, .pc, .status, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  io_space far (.mclk, .io_re, .io_we, .io_addr, .io_wdata, .io_rd_data);

  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic taken(op_type o, logic [2:0] b, logic [7:0] s);
    case (o)
      op_branch_flag_set:   return s[b];
      op_branch_flag_clear: return !s[b];
      op_branch_signed_ge:  return !(s[2] ^ s[3]);
      op_branch_signed_lt:  return s[2] ^ s[3];
      default:              return 1'b0;
    endcase
  endfunction

  // Carry out in bit 8
  function automatic logic [8:0] shf(op_type o, logic [7:0] v, logic c);
    case (o)
      op_shift_left_logical:  return {v[7], v[6:0], 1'b0};
      op_rotate_left_carry:   return {v[7], v[6:0], c};
      op_shift_right_logical: return {v[0], 1'b0, v[7:1]};
      op_rotate_right_carry:  return {v[0], c, v[7:1]};
      default:                return {v[0], v[7], v[7:1]};
    endcase
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_val(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(string nm, logic e, logic g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic tmo(int n);
    if (n >= 20)
    begin
      err_count++;
      $display("mismatch handshake expected answer seen none");
      complete_run();
    end
  endtask

  task automatic av(logic wr, logic [3:0] a, logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    tmo(n);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic exec(op_type o, logic [6:0] k, logic [2:0] b, logic [4:0] a, logic [7:0] v);
    int n;
    logic tk;
    logic wr;
    logic [8:0] sh;
    logic [7:0] e;
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_op <= o;
    instr_offset <= k;
    instr_index <= b;
    instr_io_addr <= a;
    instr_rd_val <= v;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (instr_ready === 1'b1)
        break;
    end
    tmo(n);
    instr_valid <= 1'b0;
    tk = taken(o, b, st);
    pcx = pcx + 12'h1 + (tk ? {{5{k[6]}}, k} : 12'h000);
    wr = (o inside {[op_shift_left_logical:op_shift_right_arith]}) || o == op_tflag_to_bit;
    sh = shf(o, v, st[0]);
    e = v;
    e[b] = st[6];
    if (o != op_tflag_to_bit)
      e = sh[7:0];
    if (o inside {[op_shift_left_logical:op_shift_right_arith]})
      st[3:0] = {sh[7] ^ sh[8], sh[7], sh[7:0] == 8'h00, sh[8]};
    if (o == op_flag_set_indexed || o == op_flag_clear_indexed)
      st[b] = (o == op_flag_set_indexed);
    if (o == op_bit_to_tflag)
      st[6] = v[b];
    #1;
    chk_val("pc", pcx, pc);
    chk_val("status", st, status);
    if (wr)
      chk_val("reg_wdata", e, reg_wdata);
    chk_bit("reg_we", wr, reg_we);
    if (o inside {[op_branch_flag_set:op_branch_signed_lt]})
      chk_bit("ready", !tk, instr_ready);
    if (o == op_io_bit_set || o == op_io_bit_clear)
    begin
      chk_bit("io_re", 1'b1, io_re);
      chk_val("io_addr", a, io_addr);
      chk_bit("ready", 1'b0, instr_ready);
      e = iom[a];
      e[b] = (o == op_io_bit_set);
      iom[a] = e;
      @(posedge mclk);
      #1;
      chk_bit("io_we", 1'b1, io_we);
      chk_val("io_wdata", e, io_wdata);
    end
    if (tk || o == op_io_bit_set || o == op_io_bit_clear)
    begin
      if (tk)
        @(posedge mclk);
      #1;
      chk_bit("ready", 1'b1, instr_ready);
    end
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr_op = op_nop;
    instr_offset = 7'h00;
    instr_index = 3'h0;
    instr_io_addr = 5'h00;
    instr_rd_val = 8'h00;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_count = 0;
    n_tests = 0;
    rs = 32'hfac2d60f;
    st = 8'h00;
    pcx = 12'h000;
    for (int i = 0; i < 32; i++)
      iom[i] = 8'(i * 29) ^ 8'h5a;
    repeat (4) @(posedge mclk);
    #1;
    chk_val("reset status", 8'h00, status);
    chk_val("reset pc", 12'h000, pc);
    chk_bit("reset ready", 1'b1, instr_ready);
    chk_bit("reset waitrequest", 1'b1, avs_waitrequest);
    chk_bit("reset io_we", 1'b0, io_we);
    @(posedge mclk);
    rstn <= 1'b1;
    av(1'b1, ADDR_STATUS, 32'h000000a5, d);
    st = 8'ha5;
    av(1'b0, ADDR_STATUS, 32'h0, d);
    chk_val("bus status", 32'h000000a5, d);
    av(1'b1, 4'h8, 32'hffffffff, d);
    av(1'b0, 4'h8, 32'h0, d);
    chk_val("bus unmapped", 32'h0, d);
    av(1'b1, ADDR_PC, 32'h00000ffe, d);
    pcx = 12'hffe;
    $display("test bus done");
    // Wrap of pc at both offset extremes
    for (int i = 0; i < 8; i++)
    begin
      exec(op_flag_set_indexed, 7'h00, 3'(i), 5'h00, 8'h00);
      exec(op_branch_flag_set, 7'h40, 3'(i), 5'h00, 8'h00);
      exec(op_flag_clear_indexed, 7'h00, 3'(i), 5'h00, 8'h00);
      exec(op_branch_flag_set, 7'h3f, 3'(i), 5'h00, 8'h00);
      exec(op_branch_flag_clear, 7'h3f, 3'(i), 5'h00, 8'h00);
    end
    exec(op_io_bit_set, 7'h00, 3'h7, 5'h1f, 8'h00);
    exec(op_io_bit_clear, 7'h00, 3'h0, 5'h1f, 8'h00);
    $display("test corner done");
    for (int i = 0; i < 400; i++)
    begin
      d = rnd();
      if (d[31:30] == 2'b00)
      begin
        // Read data of a write is the old status, so keep the written value first
        st = d[29:22];
        av(1'b1, ADDR_STATUS, {24'h0, st}, d);
      end
      d = rnd();
      exec(op_type'(d[3:0]), d[10:4], d[13:11], d[18:14], d[26:19]);
    end
    av(1'b0, ADDR_PC, 32'h0, d);
    chk_val("bus pc", {20'h0, pcx}, d);
    av(1'b0, ADDR_STATUS, 32'h0, d);
    chk_val("bus status", {24'h0, st}, d);
    $display("test random done");
    complete_run();
  end
endmodule
